// file: design/lmb_cycle_ctrl.sv
// local memory bus cycle sequencer with multiplexed address/data bus
`include "lmb_consts.svh"

module lmb_cycle_ctrl
  import lmb_pkg::*;
(
  // clock and reset
  input  wire logic                   mclk_i,
  input  wire logic                   sys_rst_i,
  // core request side
  input  wire logic                   req_valid_i,
  input  req_s                        req_i,
  output logic                        req_ready_o,
  input  wire logic [`LMB_DATA_W-1:0] wdata_i,
  output logic                        beat_done_o,
  output logic                        fault_o,
  output logic [`LMB_DATA_W-1:0]      rdata_o,
  // mode and arbitration
  input  wire logic                   emulation_mode_i,
  input  wire logic                   bus_priority_lost_i,
  // multiplexed address/data bus
  input  wire logic [`LMB_DATA_W-1:0] local_addr_data_bus_i,
  output logic [`LMB_DATA_W-1:0]      local_addr_data_bus_o,
  output logic                        local_addr_data_bus_oe_o,
  // strobes and transceiver enables
  output logic                        addr_latch_strobe_o,
  output logic                        row_strobe_n_o,
  output logic [`LMB_LANES-1:0]       col_strobe_n_o,
  output logic                        xcvr_inbound_en_o,
  output logic                        xcvr_outbound_en_n_o,
  // memory decode answers
  input  wire logic                   local_ready_in_i,
  input  wire logic                   bus_fault_in_i,
  input  wire logic                   burst_capable_n_i,
  input  wire logic                   narrow_port_n_i,
  // emulation mapping controls
  output logic                        map_select_o,
  output logic                        map_size_o
);

  // ----------------------------------------------------------------------
  // state and registers
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_ADDR = 6'b000010,
    S_ROW  = 6'b000100,
    S_COL  = 6'b001000,
    S_TERM = 6'b010000,
    S_HOLD = 6'b100000
  } state_e;

  state_e                 state_r,   state_nxt;
  req_s                   cur_r,     cur_nxt;
  logic                   half_r,    half_nxt;
  logic                   narrow_r,  narrow_nxt;
  logic [`LMB_DATA_W-1:0] lad_r,     lad_nxt;
  logic                   oe_r,      oe_nxt;
  logic [`LMB_DATA_W-1:0] rdata_r,   rdata_nxt;
  logic                   fault_r,   fault_nxt;
  logic                   msel_r,    msel_nxt;
  logic                   msize_r,   msize_nxt;
  pins_s                  smp_r,     smp_nxt;
  term_e                  term;
  logic                   bus_cyc;
  logic                   data_cyc;
  logic                   is_wr;
  logic                   more;
  logic                   split_go;

  // ----------------------------------------------------------------------
  // input sampling
  // ----------------------------------------------------------------------
  // sample every clock
  // decisions use last edge's sample, so a glitch never splits a choice
  always_comb begin
    smp_nxt = '{local_ready_in_i, bus_fault_in_i, burst_capable_n_i,
                narrow_port_n_i, bus_priority_lost_i, local_addr_data_bus_i};
  end

  always_ff @(posedge mclk_i) begin
    smp_r <= smp_nxt;
  end

  // cycle class of the current request
  assign is_wr    = (cur_r.kind == K_WRITE);
  assign bus_cyc  = (cur_r.kind != K_INTERNAL);
  assign data_cyc = (cur_r.kind == K_READ) || is_wr;
  assign more     = (cur_r.beats_m1 != '0);
  // first narrow half: the word is not finished, so no beat ends yet
  assign split_go = data_cyc && !half_r && !smp_r.narrow_n &&
                    !emulation_mode_i;

  lmb_term_decode u_term (
    .rdy_i    (smp_r.rdy),
    .flt_i    (smp_r.flt),
    .emu_i    (emulation_mode_i),
    .ignore_i (!bus_cyc),
    .term_o   (term)
  );

  // ----------------------------------------------------------------------
  // cycle sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt  = state_r;
    cur_nxt    = cur_r;
    half_nxt   = half_r;
    narrow_nxt = narrow_r;
    lad_nxt    = lad_r;
    oe_nxt     = 1'b0;
    rdata_nxt  = rdata_r;
    fault_nxt  = 1'b0;
    msel_nxt   = msel_r;
    msize_nxt  = msize_r;
    unique case (state_r)
      S_IDLE: begin
        if (req_valid_i) begin
          cur_nxt    = req_i;
          half_nxt   = 1'b0;
          narrow_nxt = 1'b0;
          if (req_i.kind == K_INTERNAL) begin
            // no bus activity at all for internal cycles
            state_nxt = S_TERM;
          end else begin
            // address on 31..4, status on 3..0
            lad_nxt   = {req_i.addr, req_i.status};
            oe_nxt    = 1'b1;
            state_nxt = S_ADDR;
          end
        end
      end
      S_ADDR: begin
        // strobe falls on leaving, address still held this cycle
        oe_nxt    = is_wr;
        lad_nxt   = is_wr ? wdata_i : lad_r;
        state_nxt = S_ROW;
      end
      S_ROW: begin
        oe_nxt    = is_wr;
        state_nxt = S_COL;
      end
      S_COL: begin
        oe_nxt    = is_wr;
        state_nxt = S_TERM;
      end
      S_TERM: begin
        oe_nxt = is_wr;
        if (bus_cyc && smp_r.lost) begin
          oe_nxt    = 1'b0;
          half_nxt  = 1'b0;
          state_nxt = S_HOLD;
        end else begin
          unique case (term)
            TERM_WAIT: begin
              state_nxt = S_TERM;
            end
            TERM_RETRY: begin
              lad_nxt   = {cur_r.addr, cur_r.status};
              oe_nxt    = 1'b1;
              half_nxt  = 1'b0;
              state_nxt = S_ADDR;
            end
            TERM_FAULT: begin
              // faulted cycle ends, rest of burst dropped
              fault_nxt = 1'b1;
              oe_nxt    = 1'b0;
              state_nxt = S_IDLE;
            end
            TERM_DONE: begin
              if (emulation_mode_i) begin
                msel_nxt  = !smp_r.burst_n;
                msize_nxt = !smp_r.narrow_n;
              end
              if (split_go) begin
                narrow_nxt = 1'b1;
                half_nxt   = 1'b1;
                rdata_nxt[`LMB_HALF_W-1:0] = smp_r.data[`LMB_HALF_W-1:0];
                lad_nxt[`LMB_HALF_W-1:0] =
                  wdata_i[`LMB_DATA_W-1:`LMB_HALF_W];
                state_nxt  = S_ROW;
              end else begin
                if (half_r) begin
                  rdata_nxt[`LMB_DATA_W-1:`LMB_HALF_W] =
                    smp_r.data[`LMB_HALF_W-1:0];
                end else begin
                  rdata_nxt = smp_r.data;
                end
                half_nxt   = 1'b0;
                narrow_nxt = 1'b0;
                if (data_cyc && more) begin
                  cur_nxt.beats_m1 = cur_r.beats_m1 - 1'b1;
                  cur_nxt.addr     = cur_r.addr + 1'b1;
                  // burst only when page mode low
                  if (!smp_r.burst_n && !emulation_mode_i) begin
                    state_nxt = S_ROW;
                  end else begin
                    lad_nxt   = {cur_nxt.addr, cur_r.status};
                    oe_nxt    = 1'b1;
                    state_nxt = S_ADDR;
                  end
                end else begin
                  oe_nxt    = 1'b0;
                  state_nxt = S_IDLE;
                end
              end
            end
          endcase
        end
      end
      S_HOLD: begin
        // bus released until priority returns, then full rerun
        if (!smp_r.lost) begin
          lad_nxt   = {cur_r.addr, cur_r.status};
          oe_nxt    = 1'b1;
          state_nxt = S_ADDR;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state_r  <= S_IDLE;
      cur_r    <= '0;
      half_r   <= 1'b0;
      narrow_r <= 1'b0;
      lad_r    <= '0;
      oe_r     <= 1'b0;
      rdata_r  <= '0;
      fault_r  <= 1'b0;
      msel_r   <= 1'b0;
      msize_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cur_r    <= cur_nxt;
      half_r   <= half_nxt;
      narrow_r <= narrow_nxt;
      lad_r    <= lad_nxt;
      oe_r     <= oe_nxt;
      rdata_r  <= rdata_nxt;
      fault_r  <= fault_nxt;
      msel_r   <= msel_nxt;
      msize_r  <= msize_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // pin and answer outputs
  // ----------------------------------------------------------------------
  // strobes decode straight from the one-hot state register
  always_comb begin
    req_ready_o              = (state_r == S_IDLE);
    beat_done_o              = (state_r == S_TERM) && !(bus_cyc && smp_r.lost)
                               && (term == TERM_FAULT ||
                                   (term == TERM_DONE && !split_go));
    local_addr_data_bus_o    = lad_r;
    local_addr_data_bus_oe_o = oe_r;
    addr_latch_strobe_o      = (state_r == S_ADDR);
    row_strobe_n_o           = !(bus_cyc &&
                                 (state_r == S_ROW || state_r == S_COL ||
                                  state_r == S_TERM));
    col_strobe_n_o           = `LMB_STROBE_OFF;
    if (bus_cyc && (state_r == S_COL || state_r == S_TERM)) begin
      col_strobe_n_o = narrow_r ? `LMB_HALF_LANES : '0;
    end
    if (emulation_mode_i && smp_r.flt) begin
      col_strobe_n_o = `LMB_STROBE_OFF;
    end
    xcvr_inbound_en_o    = (cur_r.kind == K_READ) && !row_strobe_n_o &&
                           (state_r != S_ROW || half_r);
    xcvr_outbound_en_n_o = !(is_wr && oe_r && state_r != S_ADDR);
  end

  assign fault_o      = fault_r;
  assign rdata_o      = rdata_r;
  assign map_select_o = msel_r;
  assign map_size_o   = msize_r;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  sequence term_decided(term_e t);
    state_r == S_TERM && bus_cyc && !smp_r.lost && term == t;
  endsequence
  sequence narrow_resume;
    state_r == S_ROW ##1 state_r == S_COL ##1 state_r == S_TERM;
  endsequence

  a_addr_on_bus: assert property (
    state_r == S_ADDR |-> local_addr_data_bus_oe_o &&
      local_addr_data_bus_o == {cur_r.addr, cur_r.status})
    else $error("address and status not driven in address phase");
  a_latch_fall: assert property (
    $fell(addr_latch_strobe_o) |-> $past(local_addr_data_bus_oe_o) &&
      !row_strobe_n_o)
    else $error("latch strobe fell without address on the bus");
  a_fault_end: assert property (
    term_decided(TERM_FAULT) |=> fault_o && state_r == S_IDLE)
    else $error("faulted cycle did not end with fault");
  a_retry_readdr: assert property (
    term_decided(TERM_RETRY) |=> addr_latch_strobe_o &&
      local_addr_data_bus_o[`LMB_DATA_W-1:`LMB_STAT_W] ==
      $past(cur_r.addr))
    else $error("retry did not present the address again");
  a_emu_protect: assert property (
    emulation_mode_i && $past(bus_fault_in_i) |->
      col_strobe_n_o == `LMB_STROBE_OFF)
    else $error("column strobe active on protected emulation cycle");
  a_xcvr_excl: assert property (
    !(xcvr_inbound_en_o && !xcvr_outbound_en_n_o))
    else $error("both transceiver directions enabled");
  a_wait_hold: assert property (
    term_decided(TERM_WAIT) |-> !beat_done_o ##1 state_r == S_TERM)
    else $error("cycle completed while ready low");
  a_lost_stop: assert property (
    state_r == S_TERM && bus_cyc && smp_r.lost |=>
      state_r == S_HOLD && !local_addr_data_bus_oe_o)
    else $error("waiting did not stop on lost priority");
  a_internal_done: assert property (
    state_r == S_TERM && !bus_cyc |-> beat_done_o ##1 state_r == S_IDLE)
    else $error("internal cycle waited on ready");
  a_narrow_split: assert property (
    state_r == S_TERM && bus_cyc && !smp_r.lost && term == TERM_DONE &&
      split_go |-> !beat_done_o ##1 half_r ##0 narrow_resume)
    else $error("narrow port did not get a second half transfer");

endmodule

// file: design/lmb_consts.svh
// constants, bus layout and strobe levels, for the local memory bus cycle controller
`ifndef LMB_CONSTS_SVH
`define LMB_CONSTS_SVH

// ----------------------------------------------------------------------
// bus layout
// ----------------------------------------------------------------------
`define LMB_DATA_W    32
`define LMB_ADDR_W    28
`define LMB_STAT_W    4
`define LMB_HALF_W    16
`define LMB_LANES     4
`define LMB_BEAT_W    2

// ----------------------------------------------------------------------
// idle and narrow-half column strobe levels
// ----------------------------------------------------------------------
`define LMB_STROBE_OFF 4'hf
`define LMB_HALF_LANES 4'hc

`endif

// file: design/lmb_pkg.sv
// types shared by the local memory bus cycle controller
`include "lmb_consts.svh"

package lmb_pkg;

  // cycle kinds that the core can ask for
  typedef enum logic [2:0] {
    K_READ     = 3'h0,
    K_WRITE    = 3'h1,
    K_SXFER    = 3'h2,
    K_REFRESH  = 3'h3,
    K_INTERNAL = 3'h4
  } cyc_kind_e;

  // termination status of one column access
  typedef enum logic [1:0] {
    TERM_DONE  = 2'h0,
    TERM_WAIT  = 2'h1,
    TERM_FAULT = 2'h2,
    TERM_RETRY = 2'h3
  } term_e;

  // request from the core
  typedef struct packed {
    logic [`LMB_ADDR_W-1:0] addr;
    logic [`LMB_STAT_W-1:0] status;
    cyc_kind_e              kind;
    logic [`LMB_BEAT_W-1:0] beats_m1;
  } req_s;

  // decode inputs and bus data, sampled together
  typedef struct packed {
    logic                   rdy;
    logic                   flt;
    logic                   burst_n;
    logic                   narrow_n;
    logic                   lost;
    logic [`LMB_DATA_W-1:0] data;
  } pins_s;

endpackage

// file: design/lmb_term_decode.sv
// decodes sampled ready and fault into a cycle termination status
module lmb_term_decode
  import lmb_pkg::*;
(
  // sampled inputs
  input  wire logic  rdy_i,
  input  wire logic  flt_i,
  // mode
  input  wire logic  emu_i,
  input  wire logic  ignore_i,
  // result
  output term_e      term_o
);

  // termination status decode
  // in emulation the fault only write-protects, so it never ends the cycle
  always_comb begin
    if (ignore_i) begin
      term_o = TERM_DONE;
    end else if (flt_i && !emu_i) begin
      // fault with ready low is a retry
      term_o = rdy_i ? TERM_FAULT : TERM_RETRY;
    end else begin
      term_o = rdy_i ? TERM_DONE : TERM_WAIT;
    end
  end

endmodule

// file: testbench/mem_decode_model.sv
// memory decode logic, address latch and data transceivers of the far side
module mem_decode_model
  import lmb_pkg::*;
(
  // clock and device pins
  input  wire logic        mclk_i,
  input  wire logic [31:0] ad_i,
  input  wire logic        ale_i,
  input  wire logic        row_n_i,
  input  wire logic [3:0]  col_n_i,
  input  wire logic        in_en_i,
  input  wire logic        out_en_n_i,
  // decode answers and read data
  output logic             rdy_o,
  output logic             flt_o,
  output logic             burst_n_o,
  output logic             narrow_n_o,
  output logic [31:0]      ad_o,
  // scenario settings and last write seen
  input  wire logic [3:0]  waits_i,
  input  wire logic [1:0]  mode_i,
  input  wire logic        burst_i,
  input  wire logic        narrow_i,
  output logic [31:0]      wr_o
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [27:0] adr = 28'h0;
  logic [3:0]  cnt = 4'h0;
  logic        retried = 1'b0;
  logic        rt;
  logic [31:0] word;

  // memory word is derived from its address; one retry owed in mode 2
  assign word = {4'ha, adr};
  assign rt = mode_i == 2'h2 && !retried;
  assign burst_n_o = ~burst_i;
  assign narrow_n_o = ~narrow_i;

  initial begin
    rdy_o = 1'b0;
    flt_o = 1'b0;
    ad_o = 32'h0;
    wr_o = 32'h0;
  end

  always @(ale_i or ad_i) begin
    if (ale_i)
      adr = ad_i[31:4];
  end

  // ready, fault, retry
  // answers move at the falling edge so the device sees settled levels;
  // mode 1 holds the fault line high for the whole scenario
  always @(negedge mclk_i) begin
    if (row_n_i) begin
      cnt <= 4'h0;
      rdy_o <= 1'b0;
    end else begin
      if (cnt != 4'hf)
        cnt <= cnt + 4'h1;
      rdy_o <= cnt > waits_i && !rt;
    end
    flt_o <= mode_i == 2'h1 || (rt && !row_n_i && cnt > waits_i);
  end

  // read data only while inbound is enabled, else a changing pattern
  always @(negedge mclk_i) begin
    if (!in_en_i)
      ad_o <= ~ad_o;
    else if (!narrow_i)
      ad_o <= word;
    // upper half comes second on the low lanes
    else if (col_n_i == 4'hc)
      ad_o <= {~word[15:0], word[31:16]};
    else
      ad_o <= {~word[31:16], word[15:0]};
  end

  // retry bookkeeping and write capture at the sampling edge
  always @(posedge mclk_i) begin
    if (mode_i != 2'h2)
      retried <= 1'b0;
    // a fault left over from an earlier mode must not use up the retry
    else if (flt_o && !rdy_o && !row_n_i)
      retried <= 1'b1;
    if (rdy_o && !out_en_n_i && col_n_i != 4'hf)
      wr_o <= ad_i;
  end
endmodule

// file: testbench/local_memory_bus_interface_tb.sv
// self-checking bench for the local memory bus cycle controller
module local_memory_bus_interface_tb
  import lmb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic        mclk_i = 1'b0;
  logic        sys_rst_i = 1'b1;
  logic        req_valid_i = 1'b0;
  req_s        req_i = '0;
  logic [31:0] wdata_i = 32'h0;
  logic        emu = 1'b0;
  logic        lost = 1'b0;
  logic [3:0]  waits = 4'h0;
  logic [1:0]  mode = 2'h0;
  logic        burst_ok = 1'b0;
  logic        narrow = 1'b0;
  logic [31:0] ad_in, ad_out, rdata, wr_word, lat_last;
  logic [3:0]  col_n;
  logic        oe, ale, row_n, in_en, out_en_n, rdy, flt, brst_n, nar_n;
  logic        req_rdy, done, fault, map_sel, map_size, saw_in, saw_out;
  int          num_errors = 0;
  int          tests_run = 0;
  int          first_k, lat_cnt, row_cnt, col_cnt;

  lmb_cycle_ctrl DUT (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .req_ready_o(req_rdy), .wdata_i(wdata_i),
    .beat_done_o(done), .fault_o(fault), .rdata_o(rdata),
    .emulation_mode_i(emu), .bus_priority_lost_i(lost),
    .local_addr_data_bus_i(ad_in), .local_addr_data_bus_o(ad_out),
    .local_addr_data_bus_oe_o(oe), .addr_latch_strobe_o(ale),
    .row_strobe_n_o(row_n), .col_strobe_n_o(col_n),
    .xcvr_inbound_en_o(in_en), .xcvr_outbound_en_n_o(out_en_n),
    .local_ready_in_i(rdy), .bus_fault_in_i(flt),
    .burst_capable_n_i(brst_n), .narrow_port_n_i(nar_n),
    .map_select_o(map_sel), .map_size_o(map_size)
  );

  mem_decode_model u_mem (
    .mclk_i(mclk_i), .ad_i(ad_out), .ale_i(ale), .row_n_i(row_n),
    .col_n_i(col_n), .in_en_i(in_en), .out_en_n_i(out_en_n),
    .rdy_o(rdy), .flt_o(flt), .burst_n_o(brst_n), .narrow_n_o(nar_n),
    .ad_o(ad_in), .waits_i(waits), .mode_i(mode), .burst_i(burst_ok),
    .narrow_i(narrow), .wr_o(wr_word)
  );

  // 10 MHz clock
  initial begin
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // one request; pins are followed until nb beats end, then one idle cycle
  // so the next request is never offered while the sequencer is busy
  task automatic run_op(input cyc_kind_e kind, input logic [27:0] adr,
                        input logic [1:0] bm1, input int nb);
    int k;
    int b;
    logic pl;
    logic pr;
    logic [3:0] pc;
    {k, b, first_k, lat_cnt, row_cnt, col_cnt} = 192'h0;
    {pl, pr, pc, saw_in, saw_out} = 8'h7c;
    req_i = '{adr, 4'h5, kind, bm1};
    req_valid_i = 1'b1;
    while (b < nb && k < 300) begin
      @(negedge mclk_i);
      req_valid_i = 1'b0;
      k++;
      if (ale && !pl)
        lat_cnt++;
      if (ale)
        lat_last = ad_out;
      if (ale)
        check(oe, 1'b1);
      if (!row_n && pr)
        row_cnt++;
      if (col_n != 4'hf && pc == 4'hf)
        col_cnt++;
      saw_in |= in_en;
      saw_out |= !out_en_n;
      {pl, pr, pc} = {ale, row_n, col_n};
      if (done === 1'b1 && first_k == 0)
        first_k = k;
      if (done === 1'b1)
        b++;
    end
    check(b, nb);
    @(negedge mclk_i);
  endtask

  // zero-wait read: address phase, latency, enables, idle levels
  task automatic t_read();
    run_op(K_READ, 28'h0123456, 2'h0, 1);
    check(first_k, 32'h4);
    check(lat_cnt, 32'h1);
    check(lat_last, 32'h01234565);
    check({saw_in, saw_out}, 32'h2);
    check(rdata, 32'ha0123456);
    check({ale, row_n, col_n, in_en, out_en_n}, 32'h7d);
  endtask

  // write held three cycles by the ready line
  task automatic t_write();
    waits = 4'h3;
    wdata_i = 32'hc3a55a3c;
    run_op(K_WRITE, 28'h0000abc, 2'h0, 1);
    check(first_k, 32'h7);
    check({saw_in, saw_out}, 32'h1);
    check(wr_word, 32'hc3a55a3c);
    waits = 4'h0;
  endtask

  // refresh and serial transfer also stretch with ready
  task automatic t_kinds();
    cyc_kind_e kd[2] = '{K_REFRESH, K_SXFER};
    waits = 4'h2;
    foreach (kd[i]) begin
      run_op(kd[i], 28'h0000010, 2'h0, 1);
      check(first_k, 32'h6);
      check({saw_in, saw_out}, 32'h0);
    end
    waits = 4'h0;
  endtask

  // internal cycle ends at once although ready stays low
  task automatic t_internal();
    run_op(K_INTERNAL, 28'h0000020, 2'h0, 1);
    check(first_k, 32'h1);
    check(lat_cnt, 32'h0);
  endtask

  // fault on the first beat of a burst drops the second beat
  task automatic t_fault();
    mode = 2'h1;
    burst_ok = 1'b1;
    run_op(K_READ, 28'h0000030, 2'h1, 1);
    check(fault, 1'b1);
    check(req_rdy, 1'b1);
    mode = 2'h0;
    burst_ok = 1'b0;
  endtask

  // retry answered in mid-wait re-presents the same address
  task automatic t_retry();
    mode = 2'h2;
    waits = 4'h1;
    run_op(K_READ, 28'h0000040, 2'h0, 1);
    check(lat_cnt, 32'h2);
    check(lat_last, 32'h00000405);
    check(fault, 1'b0);
    check(rdata, 32'ha0000040);
    mode = 2'h0;
    waits = 4'h0;
  endtask

  // emulation: fault write-protects, decode inputs become map controls
  task automatic t_emul();
    emu = 1'b1;
    mode = 2'h1;
    for (int i = 0; i < 2; i++) begin
      burst_ok = (i == 0);
      narrow = (i == 1);
      run_op(K_WRITE, 28'h0000050, 2'h0, 1);
      check(col_cnt, 32'h0);
      check(fault, 1'b0);
      check(map_sel, burst_ok);
      check(map_size, narrow);
      check(lat_cnt, 32'h1);
    end
    {emu, mode, burst_ok, narrow} = 5'h0;
  endtask

  // two beats: one row cycle when burst capable, two full cycles if not
  task automatic t_burst();
    for (int i = 0; i < 2; i++) begin
      burst_ok = (i == 0);
      run_op(K_READ, 28'h0000060, 2'h1, 2);
      check(lat_cnt, i ? 32'h2 : 32'h1);
      check(row_cnt, i ? 32'h2 : 32'h1);
      check(col_cnt, 32'h2);
      check(lat_last, i ? 32'h00000615 : 32'h00000605);
    end
    burst_ok = 1'b0;
  endtask

  // narrow port: two halves on the low lanes, one word delivered
  task automatic t_narrow();
    narrow = 1'b1;
    // upper half differs from the last word read, so a lost half shows
    run_op(K_READ, 28'h1230070, 2'h0, 1);
    check(rdata, 32'ha1230070);
    check(req_rdy, 1'b1);
    narrow = 1'b0;
  endtask

  // priority lost while waiting: cycle restarts with a new address phase
  task automatic t_lost();
    waits = 4'h6;
    fork
      run_op(K_READ, 28'h0000080, 2'h0, 1);
      begin
        repeat (5) @(negedge mclk_i);
        lost = 1'b1;
        repeat (3) @(negedge mclk_i);
        lost = 1'b0;
      end
    join
    check(lat_cnt, 32'h2);
    check(rdata, 32'ha0000080);
    waits = 4'h0;
  endtask

  // reset for two edges, then the scenarios in turn
  initial begin
    repeat (2) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    t_read();
    t_write();
    t_kinds();
    t_internal();
    t_fault();
    t_retry();
    t_emul();
    t_burst();
    t_narrow();
    t_lost();
    final_report();
  end

  // watchdog well beyond the hundred or so cycles the scenarios need
  initial begin
    repeat (3000) @(posedge mclk_i);
    num_errors++;
    final_report();
  end
endmodule
